// ===== verilog/ectmr_consts.svh
// constants for the prescaled eight-bit cycle counter: offsets, fields, resets
`ifndef ECTMR_CONSTS_SVH
`define ECTMR_CONSTS_SVH

// apb byte offsets
`define ECTMR_OFF_COUNT     12'h000
`define ECTMR_OFF_OPTION    12'h004
`define ECTMR_OFF_INTCTL    12'h008
`define ECTMR_OFF_IRQ_STAT  12'h00c
`define ECTMR_OFF_IRQ_MASK  12'h010

// option register fields
`define ECTMR_OPT_SRC_BIT   5
`define ECTMR_OPT_EDGE_BIT  4
`define ECTMR_OPT_PSA_BIT   3
`define ECTMR_OPT_PS_LSB    0

// interrupt control register fields
`define ECTMR_ICR_IE_BIT    5
`define ECTMR_ICR_IF_BIT    2

// reset values
`define ECTMR_OPTION_RST    8'hff
`define ECTMR_COUNT_RST     8'h00
`define ECTMR_MASK_RST      1'h0

// cycles of increment inhibit after a count write
`define ECTMR_WR_INHIBIT    2'h2

`endif

// ===== verilog/ectmr_pkg.sv
// types shared by the prescaled eight-bit cycle counter files
package ectmr_pkg;
    typedef logic [7:0] ectmr_byte_t;   // register byte
    typedef logic [2:0] ectmr_ratio_t;  // prescale ratio field
endpackage

// ===== verilog/ectmr_edge_det.sv
// edge detector for the external count pin with selectable polarity
`timescale 1ns/100ps
`include "ectmr_consts.svh"
module ectmr_edge_det (
    input  wire logic core_clk_i,      // core clock
    input  wire logic rst_n_i,         // async reset, low active
    input  wire logic clk_en_i,        // freeze when low
    input  wire logic pin_i,           // external count pin level
    input  wire logic falling_i,       // 1 = falling edge counts
    output logic      edge_o           // one-cycle edge pulse
);
    import ectmr_pkg::*;

    typedef struct packed {
        logic prev;                    // last sampled pin level
    } ectmr_edge_state_t;

    ectmr_edge_state_t st;             // registered state
    ectmr_edge_state_t next_st;        // next state

    // next state: just follow the pin
    always_comb begin
        next_st      = st;
        next_st.prev = pin_i;
    end

    // register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else if (clk_en_i) begin
            st <= next_st;
        end
    end

    // rising or falling by polarity; gated so a frozen block sees no edge
    assign edge_o = clk_en_i & (falling_i ? (st.prev & ~pin_i)
                                          : (~st.prev & pin_i));
endmodule

// ===== verilog/ectmr_prescaler.sv
// shared eight-bit prescaler, serving the counter or the watchdog
`timescale 1ns/100ps
`include "ectmr_consts.svh"
module ectmr_prescaler (
    input  wire logic            core_clk_i,   // core clock
    input  wire logic            rst_n_i,      // async reset, low active
    input  wire logic            clk_en_i,     // freeze when low
    input  wire logic            tick_i,       // source event to divide
    input  wire logic            clear_i,      // clear the prescaler
    input  wire ectmr_pkg::ectmr_ratio_t ratio_i, // ratio field
    output logic                 tick_o        // divided event pulse
);
    import ectmr_pkg::*;

    typedef struct packed {
        logic [7:0] cnt;               // hidden count, never on the bus
    } ectmr_ps_state_t;

    ectmr_ps_state_t st;               // registered state
    ectmr_ps_state_t next_st;          // next state
    logic [7:0]      ps_mask;          // low bits that must all be one

    // ratio n gives 2^(n+1): low n+1 bits of the running count all one
    always_comb begin
        ps_mask = 8'hff >> (3'h7 - ratio_i);
        tick_o  = clk_en_i & tick_i & ~clear_i
                  & ((st.cnt & ps_mask) == ps_mask);
    end

    // next state: clear wins, else count source events
    always_comb begin
        next_st = st;
        if (clear_i) begin
            next_st.cnt = 8'h00;
        end else if (tick_i) begin
            next_st.cnt = st.cnt + 8'h01;
        end
    end

    // register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else if (clk_en_i) begin
            st <= next_st;
        end
    end
endmodule

// ===== verilog/ectmr_top.sv
// prescaled eight-bit cycle counter unit with apb registers and interrupt
// Notes on behaviour
// - source select clear means instruction-cycle timer
// - no prescaler: count once per cycle
// - count write inhibits increment two cycles
// - source select set counts external pin
// - edge select: clear rising, set falling
// - assign bit clear gives prescaler here
// - prescaler count is never readable/writable
// - prescaled ratios one to two through 256
// - wrap ff to 00 sets overflow flag
// - interrupt request only while enable set; irq_o also rises on mask_ovf with stat_ovf
// - flag sticky until software clears it
// - counter stops during sleep
// - one prescaler, one user at a time
// - prescaler is an eight-bit counter
// - count write clears assigned prescaler
// - option low nibble: assign bit, ratio
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "ectmr_consts.svh"
module ectmr_top (
    input  wire logic        core_clk_i,     // core clock, 100 MHz
    input  wire logic        rst_n_i,        // async reset, low active
    input  wire logic        clk_en_i,       // freeze all state when low
    input  wire logic        insn_cycle_i,   // one pulse per instruction cycle
    input  wire logic        sleep_i,        // processor asleep
    input  wire logic        ext_count_i,    // external count pin level
    input  wire logic        wdt_tick_i,     // watchdog output event
    input  wire logic        wdt_clear_i,    // watchdog clear instruction
    input  wire logic        psel,           // apb select
    input  wire logic        penable,        // apb enable
    input  wire logic        pwrite,         // apb direction
    input  wire logic [11:0] paddr,          // apb byte address
    input  wire logic [31:0] pwdata,         // apb write data
    output logic             pready,         // apb ready
    output logic [31:0]      prdata,         // apb read data
    output logic             pslverr,        // apb error
    output logic             wdt_tick_o,     // watchdog event after postscale
    output logic             irq_o           // level interrupt
);
    import ectmr_pkg::*;

    // registered state of the unit apart from the edge detector and prescaler
    typedef struct packed {
        ectmr_byte_t count;        // count register
        ectmr_byte_t option;       // option register
        logic        ovf_ie;       // overflow irq enable
        logic        ovf_flag;     // overflow flag
        logic        stat_ovf;     // sticky bus irq status
        logic        mask_ovf;     // bus irq mask
        logic [1:0]  inhibit;      // cycles left of write inhibit
        logic [31:0] rdata;        // registered read data
        logic        rvalid;       // access answered next edge
    } ectmr_state_t;

    ectmr_state_t st;              // registered state
    ectmr_state_t next_st;         // next state

    logic        src_ext;          // counter mode selected
    logic        psa_wdt;          // prescaler owned by watchdog
    ectmr_ratio_t ratio;           // ratio field
    logic        ext_edge;         // selected pin edge
    logic        src_tick;         // raw source event
    logic        ps_in;            // prescaler input
    logic        ps_out;           // prescaler output
    logic        ps_clear;         // prescaler clear
    logic        inc;              // increment count this cycle
    logic        wr_acc;           // apb write access phase
    logic        rd_acc;           // apb read access phase
    logic        wr_count;         // write hits count register
    logic        known;            // address decodes
    logic        wrap;             // count wraps this cycle

    // option fields
    always_comb begin
        src_ext = st.option[`ECTMR_OPT_SRC_BIT];
        psa_wdt = st.option[`ECTMR_OPT_PSA_BIT];
        ratio   = st.option[`ECTMR_OPT_PS_LSB +: 3];
    end

    ectmr_edge_det u_edge (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .clk_en_i   (clk_en_i),
        .pin_i      (ext_count_i),
        .falling_i  (st.option[`ECTMR_OPT_EDGE_BIT]),
        .edge_o     (ext_edge)
    );

    // source and prescaler steering; the prescaler serves one owner only
    always_comb begin
        src_tick = src_ext ? ext_edge : insn_cycle_i;
        ps_in    = psa_wdt ? wdt_tick_i : src_tick;
        ps_clear = psa_wdt ? wdt_clear_i : wr_count;
        wdt_tick_o = psa_wdt ? ps_out : wdt_tick_i;
    end

    ectmr_prescaler u_ps (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .clk_en_i   (clk_en_i),
        .tick_i     (ps_in),
        .clear_i    (ps_clear),
        .ratio_i    (ratio),
        .tick_o     (ps_out)
    );

    // bus decode; single wait state so reads come from a flop
    always_comb begin
        pready   = st.rvalid;
        prdata   = st.rdata;
        wr_acc   = psel & penable & pwrite & st.rvalid;
        rd_acc   = psel & penable & ~pwrite & ~st.rvalid;
        known    = (paddr == `ECTMR_OFF_COUNT)   || (paddr == `ECTMR_OFF_OPTION)
                || (paddr == `ECTMR_OFF_INTCTL)  || (paddr == `ECTMR_OFF_IRQ_STAT)
                || (paddr == `ECTMR_OFF_IRQ_MASK);
        pslverr  = st.rvalid & ~known;
        wr_count = wr_acc & (paddr == `ECTMR_OFF_COUNT);
    end

    // increment decision: sleep stops it, the inhibit window holds it
    always_comb begin
        inc  = (psa_wdt ? src_tick : ps_out)
               & ~sleep_i & (st.inhibit == 2'h0);
        wrap = inc & (st.count == 8'hff) & ~wr_count;
    end

    // next state
    always_comb begin
        next_st = st;
        // one wait state then ready
        next_st.rvalid = psel & penable & ~st.rvalid;
        // read mux; prescaler count has no address at all
        if (rd_acc) begin
            unique case (paddr)
                `ECTMR_OFF_COUNT:    next_st.rdata = {24'h0, st.count};
                `ECTMR_OFF_OPTION:   next_st.rdata = {24'h0, st.option};
                `ECTMR_OFF_INTCTL:   next_st.rdata = {26'h0, st.ovf_ie, 2'h0,
                                                      st.ovf_flag, 2'h0};
                `ECTMR_OFF_IRQ_STAT: next_st.rdata = {31'h0, st.stat_ovf};
                `ECTMR_OFF_IRQ_MASK: next_st.rdata = {31'h0, st.mask_ovf};
                default:             next_st.rdata = 32'h0;
            endcase
        end else if (psel & penable & pwrite & ~st.rvalid) begin
            // writes answer zero, so a refused write never shows stale read data
            next_st.rdata = 32'h0;
        end
        // inhibit counts down on instruction cycles
        if (st.inhibit != 2'h0 && insn_cycle_i) begin
            next_st.inhibit = st.inhibit - 2'h1;
        end
        // counting
        if (inc) begin
            next_st.count = st.count + 8'h01;
        end
        // register writes
        if (wr_acc) begin
            unique case (paddr)
                `ECTMR_OFF_COUNT: begin
                    next_st.count   = pwdata[7:0];
                    next_st.inhibit = `ECTMR_WR_INHIBIT;
                end
                `ECTMR_OFF_OPTION: next_st.option = pwdata[7:0];
                `ECTMR_OFF_INTCTL: begin
                    next_st.ovf_ie   = pwdata[`ECTMR_ICR_IE_BIT];
                    next_st.ovf_flag = pwdata[`ECTMR_ICR_IF_BIT];
                end
                `ECTMR_OFF_IRQ_STAT: begin
                    if (pwdata[0]) begin
                        next_st.stat_ovf = 1'b0;
                    end
                end
                `ECTMR_OFF_IRQ_MASK: next_st.mask_ovf = pwdata[0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        if (wrap) begin
            next_st.ovf_flag = 1'b1;
            next_st.stat_ovf = 1'b1;
        end
    end

    // register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st          <= '0;
            st.option   <= `ECTMR_OPTION_RST;
            st.count    <= `ECTMR_COUNT_RST;
            st.mask_ovf <= `ECTMR_MASK_RST;
        end else if (clk_en_i) begin
            st <= next_st;
        end
    end

    // request needs enable and flag; bus mask gates the status copy too
    assign irq_o = (st.ovf_ie & st.ovf_flag)
                 | (st.mask_ovf & st.stat_ovf);
endmodule

// ===== verif/ectmr_monitor.sv
// checker for apb timing, refusals and the sleep freeze of the counter
`timescale 1ns/100ps
`include "ectmr_consts.svh"
module ectmr_monitor (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic        sleep_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr
);
    logic [7:0] last_q;  // count seen at the latest count read
    logic       woke_q;  // counter was free to move since then
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // a read taken asleep arms the freeze check; waking or a count write disarms it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_q <= 8'h00;
            woke_q <= 1'b1;
        end else if (pready && !pwrite && paddr == `ECTMR_OFF_COUNT) begin
            last_q <= prdata[7:0];
            woke_q <= !sleep_i;
        end else if (!sleep_i || (psel && pwrite && paddr == `ECTMR_OFF_COUNT)) begin
            woke_q <= 1'b1;
        end
    end
    sequence s_wait;  // access phase still unanswered
        psel && penable && !pready;
    endsequence
    sequence s_cnt_rd;  // answer to a count read
        pready && !pwrite && paddr == `ECTMR_OFF_COUNT;
    endsequence
    property p_one_wait; s_wait |=> pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("answer late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    property p_in_access; pready |-> psel && penable; endproperty
    a_in_access: assert property (p_in_access) else $error("ready outside access");
    property p_err_high; pready && paddr > `ECTMR_OFF_IRQ_MASK |-> pslverr; endproperty
    a_err_high: assert property (p_err_high) else $error("unmapped not refused");
    property p_err_ok; pready && paddr <= `ECTMR_OFF_IRQ_MASK && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_err_ok: assert property (p_err_ok) else $error("mapped place refused");
    property p_rd_byte; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
    a_rd_byte: assert property (p_rd_byte) else $error("upper read bits set");
    property p_err_zero; pready && pslverr |-> prdata == 32'h00000000; endproperty
    a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
    property p_sleep_hold; s_cnt_rd and !woke_q |-> prdata[7:0] == last_q; endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");
endmodule
bind ectmr_top ectmr_monitor mon_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .sleep_i(sleep_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

// ===== verif/ectmr_core_model.sv
// model of the core's instruction pulses and the external count pin
`timescale 1ns/100ps
module ectmr_core_model (
    input  wire logic core_clk_i,   // core clock
    output logic      insn_cycle_o, // instruction-cycle pulse
    output logic      pin_o         // external count pin level
);
    // both idle low until the bench asks for activity
    initial begin
        insn_cycle_o = 1'b0;
        pin_o = 1'b0;
    end
    // n pulses with a gap, like slow instructions
    task automatic insn(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            insn_cycle_o <= 1'b1;
            @(posedge core_clk_i);
            insn_cycle_o <= 1'b0;
        end
    endtask
    // a new level is held long enough for the edge detector
    task automatic pin_to(input logic lv);
        @(posedge core_clk_i);
        pin_o <= lv;
        repeat (3) @(posedge core_clk_i);
    endtask
    // n full periods: one rising and one falling edge each
    task automatic edges(input int n);
        repeat (n) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
    endtask
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the prescaled eight-bit cycle counter
`timescale 1ns/100ps
`include "ectmr_consts.svh"
module tb_top;
    import ectmr_pkg::*;
    logic        core_clk_i, rst_n_i, sleep_i, insn, pin;      // clock, reset, core side
    logic        psel, penable, pwrite, pready, pslverr, irq_o; // bus and interrupt
    logic [11:0] paddr;                                        // bus address
    logic [31:0] pwdata, prdata, r;                            // bus data, last read
    logic        e;                                            // last refusal bit
    logic        clk_en, wdt_tick, wdt_clr, wdt_out;           // enable and watchdog side
    int          n_fail, n_tests, cyc, n_wdt;                  // counters
    ectmr_top dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en),
        .insn_cycle_i(insn), .sleep_i(sleep_i), .ext_count_i(pin), .wdt_tick_i(wdt_tick),
        .wdt_clear_i(wdt_clr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wdt_tick_o(wdt_out), .irq_o(irq_o));
    // watchdog-side events, counted at the edge that samples them
    always @(posedge core_clk_i) begin
        if (wdt_out === 1'b1) begin
            n_wdt++;
        end
    end
    // n one-cycle watchdog events with a gap, then settle half a cycle
    task automatic wdt(input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            wdt_tick <= 1'b1;
            @(posedge core_clk_i);
            wdt_tick <= 1'b0;
        end
        @(negedge core_clk_i);
    endtask
    ectmr_core_model pm_u (.core_clk_i(core_clk_i), .insn_cycle_o(insn), .pin_o(pin));
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    // one transfer; the request stands until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_fail++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask
    // irq is looked at once the write's edge has settled
    task automatic irqc(input logic x);
        @(negedge core_clk_i);
        chk({31'h0, irq_o}, {31'h0, x});
    endtask
    task automatic give_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic t_reset();
        apb(1'b1, 12'h020, 32'h55);
        chk({31'h0, e}, 32'h1);
        rdc(`ECTMR_OFF_OPTION, 32'hff);
        rdc(`ECTMR_OFF_COUNT, 32'h00);
        rdc(12'h020, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("reset test done");
    endtask
    task automatic t_timer();
        apb(1'b1, `ECTMR_OFF_OPTION, 32'h08);
        apb(1'b1, `ECTMR_OFF_COUNT, 32'h10);
        pm_u.insn(2);
        rdc(`ECTMR_OFF_COUNT, 32'h10);
        pm_u.insn(5);
        rdc(`ECTMR_OFF_COUNT, 32'h15);
        $display("timer test done");
    endtask
    // one edge short of two prescaled periods must give exactly one count
    task automatic t_prescale();
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, `ECTMR_OFF_OPTION, 32'h20 | k);
            apb(1'b1, `ECTMR_OFF_COUNT, 32'h0);
            pm_u.insn(2);
            pm_u.edges((4 << k) - 1);
            rdc(`ECTMR_OFF_COUNT, 32'h1);
        end
        $display("prescale test done");
    endtask
    task automatic t_edge();
        apb(1'b1, `ECTMR_OFF_OPTION, 32'h38);
        apb(1'b1, `ECTMR_OFF_COUNT, 32'h40);
        pm_u.insn(2);
        pm_u.pin_to(1'b1);
        rdc(`ECTMR_OFF_COUNT, 32'h40);
        pm_u.pin_to(1'b0);
        rdc(`ECTMR_OFF_COUNT, 32'h41);
        apb(1'b1, `ECTMR_OFF_OPTION, 32'h28);
        pm_u.pin_to(1'b1);
        rdc(`ECTMR_OFF_COUNT, 32'h42);
        pm_u.pin_to(1'b0);
        rdc(`ECTMR_OFF_COUNT, 32'h42);
        $display("edge test done");
    endtask
    task automatic t_ovf();
        apb(1'b1, `ECTMR_OFF_OPTION, 32'h08);
        apb(1'b1, `ECTMR_OFF_COUNT, 32'hfe);
        pm_u.insn(3);
        rdc(`ECTMR_OFF_INTCTL, 32'h00);
        pm_u.insn(1);
        rdc(`ECTMR_OFF_COUNT, 32'h00);
        rdc(`ECTMR_OFF_INTCTL, 32'h04);
        irqc(1'b0);
        apb(1'b1, `ECTMR_OFF_INTCTL, 32'h24);
        irqc(1'b1);
        apb(1'b1, `ECTMR_OFF_INTCTL, 32'h20);
        irqc(1'b0);
        rdc(`ECTMR_OFF_IRQ_STAT, 32'h1);
        apb(1'b1, `ECTMR_OFF_IRQ_MASK, 32'h1);
        irqc(1'b1);
        apb(1'b1, `ECTMR_OFF_IRQ_STAT, 32'h1);
        irqc(1'b0);
        $display("overflow test done");
    endtask
    task automatic t_sleep();
        @(posedge core_clk_i);
        sleep_i <= 1'b1;
        rdc(`ECTMR_OFF_COUNT, 32'h00);
        pm_u.insn(6);
        rdc(`ECTMR_OFF_COUNT, 32'h00);
        sleep_i <= 1'b0;
        pm_u.insn(3);
        rdc(`ECTMR_OFF_COUNT, 32'h03);
        $display("sleep test done");
    endtask
    // a low enable must hold the count through instruction pulses
    task automatic t_freeze();
        @(posedge core_clk_i);
        clk_en <= 1'b0;
        pm_u.insn(4);
        @(posedge core_clk_i);
        clk_en <= 1'b1;
        rdc(`ECTMR_OFF_COUNT, 32'h03);
        $display("freeze test done");
    endtask
    // watchdog events pass straight when unowned, divided and cleared when owned
    task automatic t_wdt();
        apb(1'b1, `ECTMR_OFF_OPTION, 32'h01);
        n_wdt = 0;
        wdt(3);
        chk(n_wdt, 32'h3);
        apb(1'b1, `ECTMR_OFF_OPTION, 32'h09);
        @(posedge core_clk_i);
        wdt_clr <= 1'b1;
        @(posedge core_clk_i);
        wdt_clr <= 1'b0;
        n_wdt = 0;
        wdt(6);
        chk(n_wdt, 32'h1);
        $display("watchdog test done");
    endtask
    // a hang is cut short well beyond the expected run length
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        {rst_n_i, sleep_i, psel, penable, pwrite} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {clk_en, wdt_tick, wdt_clr} = 3'h4;
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_timer();
        t_prescale();
        t_edge();
        t_ovf();
        t_sleep();
        t_freeze();
        t_wdt();
        give_verdict();
    end
endmodule
